// File: rtl/vsr_map.svh
// Constants for the slave region select and DRAM strobe block.
// Functional notes
// - Two modes selectable: memory-and-I/O with DRAM control, or I/O only.
// - Memory mode drives row and column strobes and refresh with set timing.
// - In memory mode, every address strobe fall pulls the row strobe low early.
// - Non-DRAM cycles end as row-only cycles, leaving DRAM untouched.
// - Separate row and column address buffer enables are driven in turn.
// - Local map splits into at most sixteen regions of any size.
// - Four region inputs in I/O-only mode, three in memory mode.
// - A 380-bit configuration image loads global and region settings.
// - Sixteen or eight region sets; the region input indexes the set.
// - Each set gives accepted transfer types and asserted chip selects.
// - After strobes, wait the decode delay, then sample region inputs.
// - Address modifier is compared with the selected set's allowed types.
// - On match drive chip selects and serve; otherwise ignore the cycle.
// - Swap buffer moves upper local data half onto lower and back.
`ifndef VSR_MAP_SVH
`define VSR_MAP_SVH
`define VSR_CFG_BITS     380
`define VSR_REGIONS      16
`define VSR_CS_W         6
`define VSR_GLOBAL_W     28
`define VSR_G_MODE_BIT   0
`define VSR_G_DDLY_LSB   1
`define VSR_G_RFSH_LSB   5
`define VSR_G_SWAP_BIT   21
`define VSR_SET_W        22
`define VSR_CAS_CYC      2
`define VSR_RFSH_RAS_CYC 3
`endif

// File: rtl/vsr_pkg.sv
// Types for the slave region select and DRAM strobe block.
package vsr_pkg;
  typedef enum logic [2:0] {
    VSR_IDLE, VSR_DELAY, VSR_DECIDE, VSR_SERVE, VSR_CAS, VSR_WAIT_END,
    VSR_RFSH
  } vsr_state_t;
endpackage

// File: rtl/vsr_region_select.sv
// Region select, address modifier filter and DRAM strobe logic.
`timescale 1ns/1ps
`include "vsr_map.svh"
module vsr_region_select (
  input  wire logic       mclk_in,
  input  wire logic       rst_in,
  input  wire logic       cfg_bit_in,
  input  wire logic       cfg_valid_in,
  output logic            cfg_done_out,
  input  wire logic       as_n_in,
  input  wire logic       ds_n_in,
  input  wire logic [5:0] am_in,
  input  wire logic [3:0] region_in,
  input  wire logic [1:0] dsize_in,
  input  wire logic       local_ack_in,
  output logic            ras_n_out,
  output logic            row_en_out,
  output logic            col_en_out,
  output logic [3:0]      byte_lane_enable_n_out,
  output logic [5:0]      cs_n_out,
  output logic            swap_en_n_out,
  output logic            accepted_out,
  output logic            dram_mode_out
);
  import vsr_pkg::*;
  localparam int CW = `VSR_CFG_BITS;
  localparam int SW = `VSR_SET_W;

  // Per set: 16 allowed-type bits, then 6 chip select enables.
  logic [CW-1:0]     cfg;
  logic [CW-1:0]     next_cfg;
  logic [8:0]        cfg_cnt;
  logic [8:0]        next_cfg_cnt;
  logic              next_cfg_done;
  logic              as_s1, as_s2, ds_s1, ds_s2;
  logic [3:0]        reg_s1, reg_s2;
  logic [5:0]        am_s1, am_s2;
  vsr_state_t        state, next_state;
  logic [15:0]       cnt, next_cnt;
  logic [15:0]       rfsh_cnt, next_rfsh_cnt;
  logic [3:0]        sel, next_sel;
  logic              next_ras_n, next_row, next_col, next_acc, next_swap_n;
  logic [3:0]        next_be_n;
  logic [5:0]        next_cs_n;
  logic              dram_mode;
  logic [3:0]        ddly;
  logic [15:0]       rfsh_per;
  logic [SW-1:0]     set_sel;
  logic              am_ok;
  logic              is_dram;

  assign dram_mode = cfg[`VSR_G_MODE_BIT];
  assign ddly      = cfg[`VSR_G_DDLY_LSB +: 4];
  assign rfsh_per  = cfg[`VSR_G_RFSH_LSB +: 16];
  // Memory mode ignores the top region input bit, so only eight sets apply.
  assign set_sel = cfg[`VSR_GLOBAL_W + 32'(sel) * SW +: SW];
  assign am_ok   = set_sel[am_s2[5:2]];
  // Chip select 0 marks the DRAM window in memory mode.
  assign is_dram = dram_mode && set_sel[16];

  always_comb begin
    next_cfg      = cfg;
    next_cfg_cnt  = cfg_cnt;
    next_cfg_done = cfg_done_out;
    if (!cfg_done_out && cfg_valid_in) begin
      next_cfg = {cfg_bit_in, cfg[CW-1:1]};
      next_cfg_cnt = cfg_cnt + 9'h001;
      if (cfg_cnt == 9'(CW - 1)) begin
        next_cfg_done = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      cfg <= '0;
      cfg_cnt <= 9'h000;
      cfg_done_out <= 1'b0;
      as_s1 <= 1'b1; as_s2 <= 1'b1; ds_s1 <= 1'b1; ds_s2 <= 1'b1;
      reg_s1 <= 4'h0; reg_s2 <= 4'h0; am_s1 <= 6'h00; am_s2 <= 6'h00;
    end else begin
      cfg <= next_cfg;
      cfg_cnt <= next_cfg_cnt;
      cfg_done_out <= next_cfg_done;
      as_s1 <= as_n_in; as_s2 <= as_s1;
      ds_s1 <= ds_n_in; ds_s2 <= ds_s1;
      reg_s1 <= region_in; reg_s2 <= reg_s1;
      am_s1 <= am_in; am_s2 <= am_s1;
    end
  end

  always_comb begin
    next_state    = state;
    next_cnt      = cnt;
    next_sel      = sel;
    next_ras_n    = ras_n_out;
    next_row      = row_en_out;
    next_col      = col_en_out;
    next_be_n     = byte_lane_enable_n_out;
    next_cs_n     = cs_n_out;
    next_acc      = accepted_out;
    next_swap_n   = swap_en_n_out;
    next_rfsh_cnt = (rfsh_cnt != 16'h0000) ? rfsh_cnt - 16'h0001 : 16'h0000;
    case (state)
      VSR_IDLE: begin
        // A level test, so a strobe that fell during refresh is not lost.
        if (cfg_done_out && !as_s2) begin
          next_ras_n = !dram_mode;
          next_row   = dram_mode;
          next_cnt   = {12'h000, ddly};
          next_state = VSR_DELAY;
        end else if (cfg_done_out && dram_mode && rfsh_per != 16'h0000 &&
                     rfsh_cnt == 16'h0000) begin
          next_ras_n = 1'b0;
          next_cnt   = 16'(`VSR_RFSH_RAS_CYC);
          next_state = VSR_RFSH;
        end
      end
      VSR_DELAY: begin
        if (cnt == 16'h0000 && !ds_s2) begin
          next_sel   = dram_mode ? {1'b0, reg_s2[2:0]} : reg_s2;
          next_state = VSR_DECIDE;
        end else if (cnt != 16'h0000) begin
          next_cnt = cnt - 16'h0001;
        end
        if (as_s2) begin
          next_ras_n = 1'b1;
          next_row   = 1'b0;
          next_state = VSR_IDLE;
        end
      end
      VSR_DECIDE: begin
        if (am_ok) begin
          next_acc    = 1'b1;
          next_cs_n   = ~set_sel[SW-1:16];
          next_swap_n = !(cfg[`VSR_G_SWAP_BIT] && dsize_in == 2'b01);
          next_row    = 1'b0;
          next_col    = is_dram;
          next_state  = is_dram ? VSR_CAS : VSR_SERVE;
          next_cnt    = 16'(`VSR_CAS_CYC);
        end else begin
          next_ras_n = 1'b1;
          next_row   = 1'b0;
          next_state = VSR_WAIT_END;
        end
      end
      VSR_CAS: begin
        next_be_n = 4'h0;
        if (cnt != 16'h0000) begin
          next_cnt = cnt - 16'h0001;
        end else begin
          next_state = VSR_SERVE;
        end
      end
      VSR_SERVE: begin
        if (!is_dram) begin
          next_be_n = 4'h0;
        end
        if (local_ack_in || ds_s2) begin
          next_ras_n  = 1'b1;
          next_col    = 1'b0;
          next_be_n   = 4'hF;
          next_cs_n   = 6'h3F;
          next_swap_n = 1'b1;
          next_acc    = 1'b0;
          next_state  = VSR_WAIT_END;
        end
      end
      VSR_WAIT_END: begin
        if (as_s2) begin
          next_state = VSR_IDLE;
        end
      end
      VSR_RFSH: begin
        if (cnt != 16'h0000) begin
          next_cnt = cnt - 16'h0001;
        end else begin
          next_ras_n    = 1'b1;
          next_rfsh_cnt = rfsh_per;
          next_state    = VSR_IDLE;
        end
      end
      default: next_state = VSR_IDLE;
    endcase
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      state <= VSR_IDLE;
      cnt <= 16'h0000;
      rfsh_cnt <= 16'h0000;
      sel <= 4'h0;
      ras_n_out <= 1'b1;
      row_en_out <= 1'b0;
      col_en_out <= 1'b0;
      byte_lane_enable_n_out <= 4'hF;
      cs_n_out <= 6'h3F;
      accepted_out <= 1'b0;
      swap_en_n_out <= 1'b1;
      dram_mode_out <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      rfsh_cnt <= next_rfsh_cnt;
      sel <= next_sel;
      ras_n_out <= next_ras_n;
      row_en_out <= next_row;
      col_en_out <= next_col;
      byte_lane_enable_n_out <= next_be_n;
      cs_n_out <= next_cs_n;
      accepted_out <= next_acc;
      swap_en_n_out <= next_swap_n;
      dram_mode_out <= dram_mode;
    end
  end

  property p_ras_early;
    @(posedge mclk_in) disable iff (rst_in)
      (state == VSR_IDLE && cfg_done_out && dram_mode && !as_s2)
      |=> !ras_n_out;
  endproperty
  a_ras_early: assert property (p_ras_early)
    else $error("no early row strobe");

  property p_reject;
    @(posedge mclk_in) disable iff (rst_in)
      (state == VSR_DECIDE && !am_ok) |=> (cs_n_out == 6'h3F && !accepted_out);
  endproperty
  a_reject: assert property (p_reject)
    else $error("rejected cycle served");

  property p_accept;
    @(posedge mclk_in) disable iff (rst_in)
      (state == VSR_DECIDE && am_ok) |=> accepted_out;
  endproperty
  a_accept: assert property (p_accept)
    else $error("match not served");

  property p_row_col;
    @(posedge mclk_in) disable iff (rst_in) !(row_en_out && col_en_out);
  endproperty
  a_row_col: assert property (p_row_col)
    else $error("row and col both on");

  property p_io_no_ras;
    @(posedge mclk_in) disable iff (rst_in) !dram_mode_out |-> ras_n_out;
  endproperty
  a_io_no_ras: assert property (p_io_no_ras)
    else $error("ras in I/O mode");

  property p_no_be_reject;
    @(posedge mclk_in) disable iff (rst_in)
      !accepted_out |-> byte_lane_enable_n_out == 4'hF;
  endproperty
  a_no_be_reject: assert property (p_no_be_reject)
    else $error("lanes on");

  property p_sel_mode;
    @(posedge mclk_in) disable iff (rst_in) dram_mode |-> !sel[3];
  endproperty
  a_sel_mode: assert property (p_sel_mode)
    else $error("set index too big");

  property p_rfsh_end;
    @(posedge mclk_in) disable iff (rst_in)
      (state == VSR_RFSH && cnt == 16'h0000) |=> ras_n_out;
  endproperty
  a_rfsh_end: assert property (p_rfsh_end)
    else $error("refresh stuck");

  c_accept: cover property (@(posedge mclk_in) state == VSR_DECIDE && am_ok);
  c_reject: cover property (@(posedge mclk_in) state == VSR_DECIDE && !am_ok);
  c_rfsh:   cover property (@(posedge mclk_in) state == VSR_RFSH);
endmodule

// File: test/vsr_master_model.sv
// Bus master and region decoder model facing the region select block.
`timescale 1ns/1ps
module vsr_master_model (
  input  wire logic       mclk_in,
  input  wire logic       accepted_in,
  output logic            as_n_out,
  output logic            ds_n_out,
  output logic [5:0]      am_out,
  output logic [3:0]      region_out,
  output logic            ack_out
);
  logic [31:0] addr = 32'h00000000;
  initial begin
    as_n_out = 1'b1;
    ds_n_out = 1'b1;
    am_out = 6'h00;
    ack_out = 1'b0;
  end
  // Addresses off this board present region 7, which is kept unused.
  always_comb begin
    if (addr[31:24] == 8'hFF) begin
      region_out = addr[23:20];
    end else begin
      region_out = 4'h7;
    end
  end
  task automatic xfer(input logic [31:0] a, input logic [5:0] m,
                      input int dly);
    int n;
    @(posedge mclk_in);
    #5;
    addr = a;
    am_out = m;
    as_n_out = 1'b0;
    ds_n_out = 1'b0;
    // The answer is looked at 5 ns after each rising edge, once it has settled.
    for (n = 0; n < 40 && accepted_in !== 1'b1; n++) begin
      @(posedge mclk_in);
      #5;
    end
    if (accepted_in === 1'b1) begin
      repeat (dly) begin
        @(posedge mclk_in);
        #5;
      end
      ack_out = 1'b1;
      for (n = 0; n < 20 && accepted_in === 1'b1; n++) begin
        @(posedge mclk_in);
        #5;
      end
      ack_out = 1'b0;
    end
    // Released lines do not keep their last value.
    as_n_out = 1'b1;
    ds_n_out = 1'b1;
    addr = ~a;
    am_out = ~m;
    repeat (6) @(posedge mclk_in);
    #5;
  endtask
endmodule

// File: test/vsr_region_select_tb_top.sv
// Self-checking bench for the region select and DRAM strobe block.
`timescale 1ns/1ps
module vsr_region_select_tb_top;
  logic        mclk_in = 1'b0;
  logic        rst_in = 1'b1;
  logic        cfg_bit_in = 1'b0;
  logic        cfg_valid_in = 1'b0;
  logic [1:0]  dsize_in = 2'b00;
  logic        as_n, ds_n, ack, cfg_done, ras_n, row_en, col_en, swap_n;
  logic        acc, dmode, mode, acc_seen, ras_seen, lane_seen, row_seen;
  logic        col_seen, swap_seen;
  logic [5:0]  am, cs_n, cs_seen;
  logic [3:0]  region, lanes_n;
  logic [15:0] set_am [16];
  logic [5:0]  set_cs [16];
  integer      seed = 32'h925efc78;
  int          err_count = 0;
  int          compares = 0;
  initial begin
    forever #25 mclk_in = ~mclk_in;
  end
  vsr_region_select u_vsr_region_select (.mclk_in(mclk_in),
    .rst_in(rst_in), .cfg_bit_in(cfg_bit_in), .cfg_valid_in(cfg_valid_in),
    .cfg_done_out(cfg_done), .as_n_in(as_n), .ds_n_in(ds_n), .am_in(am),
    .region_in(region), .dsize_in(dsize_in), .local_ack_in(ack),
    .ras_n_out(ras_n), .row_en_out(row_en), .col_en_out(col_en),
    .byte_lane_enable_n_out(lanes_n), .cs_n_out(cs_n),
    .swap_en_n_out(swap_n), .accepted_out(acc), .dram_mode_out(dmode));
  vsr_master_model u_vsr_master_model (.mclk_in(mclk_in),
    .accepted_in(acc), .as_n_out(as_n), .ds_n_out(ds_n), .am_out(am),
    .region_out(region), .ack_out(ack));
  always @(posedge mclk_in) begin
    if (acc === 1'b1) begin
      acc_seen <= 1'b1;
      cs_seen <= cs_n;
    end
    if (ras_n === 1'b0) ras_seen <= 1'b1;
    // Byte lanes reach the memory only when gated by chip select 0.
    if (lanes_n === 4'h0 && cs_n[0] === 1'b0) lane_seen <= 1'b1;
    if (row_en === 1'b1) row_seen <= 1'b1;
    if (col_en === 1'b1) col_seen <= 1'b1;
    if (swap_n === 1'b0) swap_seen <= 1'b1;
  end
  task automatic check(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic conclude();
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic setup(input logic m);
    logic [379:0] img;
    img = '0;
    img[0] = m;
    img[4:1] = 4'($random(seed));
    img[20:5] = 16'h0030;
    img[21] = 1'b1;
    for (int n = 0; n < 16; n++) begin
      set_am[n] = 16'($random(seed));
      set_cs[n] = 6'($random(seed));
      if (n == 3) set_am[n][0] = 1'b1;
      if (n == 7) set_am[n] = 16'h0000;
      img[28 + 22 * n +: 22] = {set_cs[n], set_am[n]};
    end
    rst_in = 1'b1;
    repeat (16) @(posedge mclk_in);
    check("reset cs_n", 8'h3F, {2'd0, cs_n});
    #5;
    rst_in = 1'b0;
    for (int i = 0; i < 380; i++) begin
      cfg_bit_in = img[i];
      cfg_valid_in = 1'b1;
      @(posedge mclk_in);
      #5;
    end
    cfg_valid_in = 1'b0;
    check("cfg_done", 8'd1, {7'd0, cfg_done});
    @(posedge mclk_in);
    #5;
    check("dram_mode", {7'd0, m}, {7'd0, dmode});
    ras_seen = 1'b0;
    repeat (8) @(posedge mclk_in);
    #5;
    check("refresh", {7'd0, m}, {7'd0, ras_seen});
  endtask
  task automatic run(input logic [31:0] a, input logic [5:0] m);
    logic [3:0] r;
    logic       ok;
    logic       ecol;
    logic       eswap;
    r = (a[31:24] == 8'hFF) ? a[23:20] : 4'h7;
    if (mode) r[3] = 1'b0;
    ok = set_am[r][m[5:2]];
    acc_seen = 1'b0;
    ras_seen = 1'b0;
    lane_seen = 1'b0;
    row_seen = 1'b0;
    col_seen = 1'b0;
    swap_seen = 1'b0;
    cs_seen = 6'h3F;
    dsize_in = 2'($random(seed));
    ecol = mode & ok & set_cs[r][0];
    eswap = ok & (dsize_in == 2'b01);
    u_vsr_master_model.xfer(a, m, int'(2'($random(seed))));
    check("accepted", {7'd0, ok}, {7'd0, acc_seen});
    check("cs_n", ok ? {2'd0, ~set_cs[r]} : 8'h3F, {2'd0, cs_seen});
    check("row strobe", {7'd0, mode}, {7'd0, ras_seen});
    check("col enable", {7'd0, ecol}, {7'd0, col_seen});
    check("swap", {7'd0, eswap}, {7'd0, swap_seen});
    if (mode) begin
      check("row enable", 8'd1, {7'd0, row_seen});
      check("lanes", {7'd0, ok & set_cs[r][0]}, {7'd0, lane_seen});
    end
  endtask
  initial begin
    #300000;
    err_count++;
    conclude();
  end
  initial begin
    for (int k = 0; k < 2; k++) begin
      mode = k[0];
      setup(mode);
      run(32'hFF312340, 6'h03);
      run(32'h12345678, 6'h03);
      repeat (12) run({8'hFF, 24'($random(seed))}, 6'($random(seed)));
      $display("test mode %0d done", k);
    end
    conclude();
  end
endmodule
